// ==== ppio_map.vh ====
`ifndef PPIO_MAP_VH
`define PPIO_MAP_VH
`define PPIO_W 8
`define PPIO_ADDR_DATA 12'h000
`define PPIO_ADDR_DIR 12'h004
`define PPIO_ADDR_PULL 12'h800
`define PPIO_ADDR_SLEW 12'h804
`define PPIO_ADDR_DRIVE 12'h808
`define PPIO_ADDR_PWR 12'h80c
`define PPIO_ADDR_LCD 12'h810
`define PPIO_PWR_ACK 0
`define PPIO_PWR_FLAG 1
`define PPIO_PWR_LCD_STOP 2
`define PPIO_LCD_FCD 2
`define PPIO_LCD_REGULATOR_REF_ENABLE 3
`define PPIO_SUPPLY_FULL 2'h3
`define PPIO_RST_DATA 8'h00
`define PPIO_RST_DIR 8'h00
`define PPIO_RST_PULL 8'h00
`define PPIO_RST_SLEW 8'hff
`define PPIO_RST_DRIVE 8'h00
`define PPIO_RST_LCD 4'h0
`define PPIO_RESP_OKAY 2'h0
`define PPIO_RESP_SLVERR 2'h2
`endif

// ==== ppio_port.v ====
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`include "ppio_map.vh"
module ppio_port #(
   parameter [7:0] LCD_PINS = 8'h30,
   parameter [7:0] OUT_ONLY = 8'h00
)
(
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // AXI4-Lite write
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Shared peripheral functions
   input wire [7:0] periph_dig_en,
   input wire [7:0] periph_dig_out,
   input wire [7:0] periph_dig_oe,
   input wire [7:0] periph_ana_en,
   // Power control
   input wire stop_partial,
   input wire stop_light,
   input wire wake_partial,
   // Pins
   input wire [7:0] pin_in,
   output reg [7:0] pin_out,
   output reg [7:0] pin_oe,
   output reg [7:0] pin_pull_en,
   output reg [7:0] pin_slew_en,
   output reg [7:0] pin_high_drive,
   output reg [7:0] pin_in_buf_en,
   output reg [7:0] pin_periph_in
);
   // Reset enters at once but leaves on a clock edge, so no flop sees a release mid-cycle
   reg rst_s1_reg;
   reg rst_s2_reg;
   wire rst_n = rst_s2_reg;
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   // Pin levels pass two flops before use; only the second stage is read
   reg [7:0] pin_s1_reg;
   reg [7:0] pin_s2_reg;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_reg <= 8'h00;
         pin_s2_reg <= 8'h00;
      end
      else
      begin
         pin_s1_reg <= pin_in;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   reg [7:0] data_reg;
   reg [7:0] dir_reg;
   reg [7:0] pull_reg;
   reg [7:0] slew_reg;
   reg [7:0] drive_reg;
   reg [3:0] lcd_reg;
   reg flag_reg;
   reg lcd_stop_reg;
   reg frozen_reg;
   reg od_mode_reg;
   reg [7:0] held_out_reg;
   reg [7:0] held_oe_reg;
   // Per-pin drive before the freeze, and next values of the registered pin outputs
   wire [7:0] drv_out;
   wire [7:0] drv_oe;
   wire [7:0] out_next;
   wire [7:0] oe_next;
   wire [7:0] pull_next;
   wire [7:0] slew_next;
   wire [7:0] drive_next;
   wire [7:0] inbuf_next;
   wire [7:0] periph_in_next;

   // Write channel: address and data taken in either order
   reg aw_ok_reg;
   reg w_ok_reg;
   reg [11:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   // Readies drop while an answer waits, so only one write is under way at a time
   assign s_axi_awready = !aw_ok_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_ok_reg && !s_axi_bvalid;
   wire do_write = aw_ok_reg && w_ok_reg && !s_axi_bvalid;
   wire [7:0] wd = w_data_reg[7:0];
   wire lane0 = w_strb_reg[0];
   reg wr_hit;
   always @*
   begin
      case (aw_addr_reg)
         `PPIO_ADDR_DATA,
         `PPIO_ADDR_DIR,
         `PPIO_ADDR_PULL,
         `PPIO_ADDR_SLEW,
         `PPIO_ADDR_DRIVE,
         `PPIO_ADDR_PWR,
         `PPIO_ADDR_LCD: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end
   // While frozen, pin configuration writes are dropped until acknowledged
   wire wr_en = do_write && lane0 && !frozen_reg;
   // The acknowledge is honoured while frozen, or the freeze could never end
   wire ack_write = do_write && lane0 && (aw_addr_reg == `PPIO_ADDR_PWR) && wd[`PPIO_PWR_ACK];

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_ok_reg <= 1'b0;
         w_ok_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PPIO_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PPIO_RESP_OKAY : `PPIO_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration registers
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_reg <= `PPIO_RST_DATA;
         dir_reg <= `PPIO_RST_DIR;
         pull_reg <= `PPIO_RST_PULL;
         slew_reg <= `PPIO_RST_SLEW;
         drive_reg <= `PPIO_RST_DRIVE;
         lcd_reg <= `PPIO_RST_LCD;
         lcd_stop_reg <= 1'b0;
         flag_reg <= 1'b0;
         frozen_reg <= 1'b0;
      end
      else
      begin
         if (wr_en)
         begin
            case (aw_addr_reg)
               `PPIO_ADDR_DATA: data_reg <= wd;
               `PPIO_ADDR_DIR: dir_reg <= wd;
               `PPIO_ADDR_PULL: pull_reg <= wd;
               `PPIO_ADDR_SLEW: slew_reg <= wd;
               `PPIO_ADDR_DRIVE: drive_reg <= wd;
               `PPIO_ADDR_LCD: lcd_reg <= wd[3:0];
               `PPIO_ADDR_PWR: lcd_stop_reg <= wd[`PPIO_PWR_LCD_STOP];
               default: lcd_reg <= lcd_reg;
            endcase
         end
         // Freeze on entry to partial power-down stop; a new stop beats an acknowledge
         if (stop_partial)
            frozen_reg <= 1'b1;
         else if (ack_write)
            frozen_reg <= 1'b0;
         // Wake sets the flag; a wake beats an acknowledge in the same cycle
         if (wake_partial)
            flag_reg <= 1'b1;
         else if (ack_write)
            flag_reg <= 1'b0;
      end
   end

   // Drive mode of LCD pins, held across stop when the LCD runs in stop
   wire full_drive = (lcd_reg[1:0] == `PPIO_SUPPLY_FULL) && lcd_reg[`PPIO_LCD_FCD] &&
      !lcd_reg[`PPIO_LCD_REGULATOR_REF_ENABLE];
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         od_mode_reg <= 1'b1;
      // With the LCD running in stop, the drive mode rides through the freeze
      else if (!(frozen_reg && lcd_stop_reg))
         od_mode_reg <= !full_drive;
   end

   // Snapshot of the pin drive, taken every cycle until the freeze starts
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         held_out_reg <= 8'h00;
         held_oe_reg <= 8'h00;
      end
      else if (!frozen_reg)
      begin
         held_out_reg <= drv_out;
         held_oe_reg <= drv_oe;
      end
   end

   genvar i;
   generate
      for (i = 0; i < `PPIO_W; i = i + 1)
      begin : g_pin
         wire ana = periph_ana_en[i];
         wire dig = periph_dig_en[i] && !ana;
         wire lcd_od = LCD_PINS[i] && od_mode_reg;
         wire want_oe = ana ? 1'b0 : (dig ? periph_dig_oe[i] : dir_reg[i]);
         wire want_out = dig ? periph_dig_out[i] : data_reg[i];
         // Open drain never drives a one; the pull-up or an outside resistor gives the high level
         assign drv_out[i] = lcd_od ? 1'b0 : want_out;
         assign drv_oe[i] = lcd_od ? (want_oe && !want_out) : want_oe;
         assign out_next[i] = frozen_reg ? held_out_reg[i] : drv_out[i];
         assign oe_next[i] = frozen_reg ? held_oe_reg[i] : drv_oe[i];
         // The pull stays on for open-drain outputs that no peripheral takes, one source of their high level
         assign pull_next[i] = pull_reg[i] && !ana && !periph_dig_en[i] &&
            (!dir_reg[i] || lcd_od);
         assign slew_next[i] = slew_reg[i] && drv_oe[i];
         assign drive_next[i] = drive_reg[i] && drv_oe[i];
         assign inbuf_next[i] = !ana && !OUT_ONLY[i];
         assign periph_in_next[i] = pin_s2_reg[i] && !ana;
      end
   endgenerate

   // Pin outputs registered, so configuration changes reach the pads glitch-free
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
         pin_pull_en <= 8'h00;
         pin_slew_en <= 8'h00;
         pin_high_drive <= 8'h00;
         pin_in_buf_en <= ~OUT_ONLY;
         pin_periph_in <= 8'h00;
      end
      else
      begin
         pin_out <= out_next;
         pin_oe <= oe_next;
         pin_pull_en <= pull_next;
         pin_slew_en <= slew_next;
         pin_high_drive <= drive_next;
         pin_in_buf_en <= inbuf_next;
         pin_periph_in <= periph_in_next;
      end
   end

   // Data read: latched value for outputs, pin level for inputs, 0 when buffer off
   wire [7:0] data_view = (dir_reg & data_reg) |
      (~dir_reg & pin_s2_reg & ~periph_ana_en & ~OUT_ONLY);

   // Byte lanes are ignored; the word address alone picks the register
   wire [11:0] rd_addr = {s_axi_araddr[11:2], 2'b00};
   reg [31:0] rd_data_next;
   reg [1:0] rd_resp_next;
   always @*
   begin
      rd_data_next = 32'h00000000;
      rd_resp_next = `PPIO_RESP_OKAY;
      case (rd_addr)
         `PPIO_ADDR_DATA: rd_data_next = {24'h000000, data_view};
         `PPIO_ADDR_DIR: rd_data_next = {24'h000000, dir_reg};
         `PPIO_ADDR_PULL: rd_data_next = {24'h000000, pull_reg};
         `PPIO_ADDR_SLEW: rd_data_next = {24'h000000, slew_reg};
         `PPIO_ADDR_DRIVE: rd_data_next = {24'h000000, drive_reg};
         `PPIO_ADDR_PWR: rd_data_next = {29'h00000000, lcd_stop_reg, flag_reg, 1'b0};
         `PPIO_ADDR_LCD: rd_data_next = {27'h0000000, od_mode_reg, lcd_reg};
         default: rd_resp_next = `PPIO_RESP_SLVERR;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PPIO_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data_next;
         s_axi_rresp <= rd_resp_next;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule

// ==== ppio_port_sva.sv ====
module ppio_port_sva #(
   parameter [7:0] LCD_PINS = 8'h30,
   parameter [7:0] OUT_ONLY = 8'h00
)
(
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Shared functions and pins
   input wire [7:0] periph_dig_en,
   input wire [7:0] periph_dig_oe,
   input wire [7:0] periph_ana_en,
   input wire [7:0] pin_oe,
   input wire [7:0] pin_pull_en,
   input wire [7:0] pin_in_buf_en
);
   // Internal reset leaves two edges after release, so checks wait for it
   reg [1:0] live;
   always @(posedge clk or negedge reset_n)
      if (!reset_n)
         live <= 2'h0;
      else if (live != 2'h3)
         live <= live + 2'h1;
   default clocking cb @(posedge clk); endclocking
   default disable iff (live != 2'h3);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   a_analog_oe: assert property ((pin_oe & $past(periph_ana_en)) == 8'h00)
      else $error("analog pin driven");
   a_analog_inbuf: assert property (pin_in_buf_en == ~($past(periph_ana_en) | OUT_ONLY))
      else $error("input buffer wrong");
   a_shared_pull: assert property ((pin_pull_en & $past(periph_dig_en | periph_ana_en)) == 8'h00)
      else $error("pull on shared pin");
   a_digital_oe: assert property (((pin_oe ^ $past(periph_dig_oe)) & $past(periph_dig_en & ~periph_ana_en) & ~LCD_PINS) == 8'h00)
      else $error("shared function lost buffer");
endmodule
bind ppio_port ppio_port_sva #(.LCD_PINS(LCD_PINS), .OUT_ONLY(OUT_ONLY)) u_sva (.clk(clk), .reset_n(reset_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .periph_dig_en(periph_dig_en),
   .periph_dig_oe(periph_dig_oe), .periph_ana_en(periph_ana_en), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
   .pin_in_buf_en(pin_in_buf_en));

// ==== tb_parallel_pin_io_control.sv ====
module tb_parallel_pin_io_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, stp = 1'b0, stl = 1'b0, wk = 1'b0;
   logic [11:0] awa = 12'h000, ara = 12'h000;
   logic [31:0] wd = 32'h0, d;
   logic [7:0] den = 8'h00, dou = 8'h00, doe = 8'h00, aen = 8'h00, pin = 8'h00, da, dr, pu, od, fr;
   logic [1:0] r;
   logic [3:0] lcd;
   logic [11:0] ra[6] = '{12'h000, 12'h004, 12'h800, 12'h804, 12'h808, 12'h810};
   logic [7:0] rx[6] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h10};
   wire awr, wrd, bv, arr, rv;
   wire [1:0] br, rr;
   wire [31:0] rdt;
   wire [7:0] po, poe, ppu, psl, phd, pib, ppi;
   int miscompares = 0, checked = 0, cyc = 0;
   ppio_port u_dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .periph_dig_en(den), .periph_dig_out(dou),
      .periph_dig_oe(doe), .periph_ana_en(aen), .stop_partial(stp), .stop_light(stl), .wake_partial(wk),
      .pin_in(pin), .pin_out(po), .pin_oe(poe), .pin_pull_en(ppu), .pin_slew_en(psl), .pin_high_drive(phd),
      .pin_in_buf_en(pib), .pin_periph_in(ppi));
   initial
      forever #5 clk = ~clk;
   task wrap_up;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         miscompares++;
         wrap_up;
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Handshakes are judged at the falling edge, where combinational readies have settled
   task wr(input logic [11:0] a, input logic [7:0] v);
      logic ha, hw, hb;
      @(posedge clk);
      awa <= a;
      wd <= {24'h000000, v};
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      hb = 1'b0;
      while (!hb)
      begin
         @(negedge clk);
         ha = awv && awr;
         hw = wv && wrd;
         hb = bv;
         r = br;
         @(posedge clk);
         if (ha)
            awv <= 1'b0;
         if (hw)
            wv <= 1'b0;
      end
      bre <= 1'b0;
      chk("bresp", 32'h0, {30'h0, r});
   endtask
   task rd(input logic [11:0] a);
      logic ha, hr;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      hr = 1'b0;
      while (!hr)
      begin
         @(negedge clk);
         ha = arv && arr;
         hr = rv;
         d = rdt;
         r = rr;
         @(posedge clk);
         if (ha)
            arv <= 1'b0;
      end
      rre <= 1'b0;
   endtask
   initial
   begin
      void'($urandom(32'hd21b));
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("pin_oe", 32'h0, poe);
      for (int i = 0; i < 6; i++)
      begin
         rd(ra[i]);
         chk("reset value", {24'h0, rx[i]}, d);
      end
      rd(12'h100);
      chk("unmapped resp", 32'h2, {30'h0, r});
      chk("unmapped data", 32'h0, d);
      for (int i = 0; i < 40; i++)
      begin
         da = 8'($urandom);
         dr = 8'($urandom);
         pu = 8'($urandom);
         lcd = i[0] ? 4'h7 : 4'($urandom);
         den <= 8'($urandom & $urandom);
         aen <= 8'($urandom & $urandom & $urandom);
         pin <= 8'($urandom);
         dou <= 8'($urandom);
         doe <= 8'($urandom);
         wr(12'h000, da);
         wr(12'h004, dr);
         wr(12'h800, pu);
         wr(12'h810, {4'h0, lcd});
         rd(12'h000);
         chk("port data", {24'h0, (dr & da) | (~dr & pin & ~aen)}, d);
         @(negedge clk);
         fr = ~(den | aen);
         od = (lcd == 4'h7) ? 8'h00 : 8'h30;
         chk("pin_oe", dr & ~(od & da) & fr, poe & fr);
         chk("pin_out", dr & da & ~od & fr, po & poe & fr);
         chk("pin_pull", pu & (~dr | od) & fr, ppu & fr);
         chk("in_buf", {24'h0, ~aen}, pib);
         chk("periph_in", {24'h0, pin & ~aen}, ppi);
      end
      den <= 8'h00;
      aen <= 8'h00;
      wr(12'h810, 8'h07);
      wr(12'h808, 8'ha5);
      wr(12'h004, 8'hff);
      wr(12'h000, 8'h0f);
      @(negedge clk);
      chk("high drive", 32'ha5, phd);
      chk("slew", 32'hff, psl);
      @(posedge clk);
      stp <= 1'b1;
      @(posedge clk);
      stp <= 1'b0;
      wr(12'h000, 8'hf0);
      @(negedge clk);
      chk("frozen out", 32'h0f, po);
      @(posedge clk);
      wk <= 1'b1;
      @(posedge clk);
      wk <= 1'b0;
      rd(12'h80c);
      chk("stop flag", 32'h2, d & 32'h2);
      wr(12'h80c, 8'h01);
      rd(12'h80c);
      chk("flag cleared", 32'h0, d & 32'h2);
      stl <= 1'b1;
      wr(12'h000, 8'hf0);
      @(negedge clk);
      chk("pin after wake", 32'hf0, po);
      wrap_up;
   end
endmodule
